//--- host_bus_model.sv
// two-wire bus host model facing the register bank's serial port
`timescale 1ns/1ps
module host_bus_model #(
  parameter logic [6:0] DEV = 7'h2a
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv,
  output logic [7:0] rd_byte,
  output logic rd_stb
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    rd_byte = 8'h00;
    rd_stb = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data moves mid-low so the synchronised scl never sees it shift
  task automatic bit_io(input logic b, output logic r);
    w(2);
    sda_drv <= b;
    w(2);
    scl <= 1'b1;
    w(4);
    r = sda_line;
    scl <= 1'b0;
  endtask
  // start or stop: sda moves while scl is high
  task automatic cond(input logic s0, input logic s1);
    w(4);
    sda_drv <= s0;
    w(4);
    scl <= 1'b1;
    w(4);
    sda_drv <= s1;
    w(4);
  endtask
  task automatic send(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
  endtask
  task automatic head(input logic [7:0] sub);
    cond(1'b1, 1'b0);
    scl <= 1'b0;
    send({DEV, 1'b0});
    send(sub);
  endtask
  task automatic write_regs(input logic [7:0] sub, input logic [7:0] d);
    head(sub);
    send(d);
    cond(1'b0, 1'b1);
  endtask
  task automatic read_regs(input logic [7:0] sub, input int n);
    logic a;
    logic [7:0] d;
    head(sub);
    cond(1'b1, 1'b0);
    scl <= 1'b0;
    send({DEV, 1'b1});
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(k == n - 1, a);
      rd_byte <= d;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
    end
    cond(1'b0, 1'b1);
  endtask
endmodule

//--- pmic_mask_status_control_regs.sv
// switch mask, status and control registers behind the two-wire port
//
// Notes on behaviour
// R1 - mask register at 0x04, resets 0x00
// R2 - bits 5..3 mask switch over-temperature faults
// R3 - bits 2..0 mask switch current-limit events
// R4 - unmasked event pulls interrupt low
// R5 - mask gates output only, flags untouched
// R6 - status at 0x05, top bits reset zero
// R7 - bit 7 shows freshness seal broken
// R8 - bit 6 shows defaults reprogrammed
// R9 - bit 5 set while adapter pin low
// R10 - bit 4 set while pushbutton pin low
// R11 - bits 3..2 show power state machine
// R12 - bits 1..0 show coin-cell charge level
// R13 - host triggers acquisition before reading level
// R14 - control at 0x06, bit0 start, resets 0x00
// R15 - writing start begins measurement, self-clears
// R16 - settled comparators set measurement-done flag
// R17 - control bit 1 enables power-fail shutdown
// R18 - reserved and read-only writes ignored, read zero
// R19 - status writes change nothing
`timescale 1ns/1ps
`include "pmic_regs_defines.svh"
module pmic_mask_status_control_regs
  import pmic_regs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `PMIC_DEV_ADDR
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [2:0] switch_fault_flag,
  input wire logic [2:0] switch_limit_flag,
  input wire logic freshness_seal,
  input wire logic defaults_modified,
  input wire logic adapter_detect_in,
  input wire logic pushbutton_in,
  input wire logic [1:0] power_state,
  input wire logic [1:0] coin_cell_level,
  input wire logic coin_cell_settled,
  input wire logic power_fail_n,
  output logic irq_out_n,
  output logic coin_cell_measure_req,
  output logic coin_cell_measure_done,
  output logic shutdown_req
);
  logic [7:0] sync_q;
  logic scl_s, sda_s, adapter_s, button_s, pf_n_s, settled_s;
  logic [1:0] level_s;
  logic scl_d, sda_d, settled_d;
  link_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] cnt_reg;
  logic rw_reg;
  logic [7:0] sub_reg;
  logic have_sub_reg;
  logic [5:0] masks_reg;
  logic pf_en_reg;
  logic acq_start_reg;
  logic seal_reg;
  logic modified_reg;
  logic irq_n_reg;
  localparam logic [7:0] CTRL_RESET = `PMIC_CTRL_RESET;

  // pins, the bus clock and comparator outputs are all asynchronous
  sync2 #(.WIDTH(8)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({scl_in, sda_in, adapter_detect_in, pushbutton_in, power_fail_n,
        coin_cell_settled, coin_cell_level}),
    .q(sync_q)
  );
  assign {scl_s, sda_s, adapter_s, button_s, pf_n_s, settled_s, level_s} =
    sync_q;

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire byte_full = (cnt_reg == `PMIC_BITS_PER_BYTE);
  wire addr_hit = (shift_reg[7:1] == DEV_ADDR);
  wire addr_done = scl_fall && state_reg == ST_ADDR && byte_full;
  wire rx_done = scl_fall && state_reg == ST_RX && byte_full;
  wire tx_load = scl_fall &&
    ((state_reg == ST_ACK && rw_reg) || state_reg == ST_RACK);
  wire wr_en = rx_done && have_sub_reg;
  wire wr_masks = wr_en && sub_reg == `PMIC_OFF_MASKS;
  wire wr_ctrl = wr_en && sub_reg == `PMIC_OFF_CTRL;
  wire settle_rise = settled_s & ~settled_d;
  wire [5:0] events = {switch_fault_flag[2], switch_fault_flag[1],
    switch_fault_flag[0], switch_limit_flag[2], switch_limit_flag[1],
    switch_limit_flag[0]};
  wire [5:0] unmasked = events & ~masks_reg;

  wire [7:0] status_word = {seal_reg, modified_reg, ~adapter_s, // [R9]
    ~button_s, power_state, level_s}; // [R10] [R11] [R12]
  wire [7:0] ctrl_word = {6'h00, pf_en_reg, acq_start_reg}; // [R14] [R18]
  wire [7:0] rd_data =
    (sub_reg == `PMIC_OFF_MASKS) ? {2'b00, masks_reg} : // [R18]
    (sub_reg == `PMIC_OFF_STATUS) ? status_word :
    (sub_reg == `PMIC_OFF_CTRL) ? ctrl_word : 8'h00;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // match the synchroniser's reset output, so no false fall after reset
      scl_d <= 1'b0;
      sda_d <= 1'b0;
      settled_d <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      settled_d <= settled_s;
    end
  end

  // byte engine: sample on the rising edge, drive on the falling edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      cnt_reg <= 4'h0;
      rw_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      cnt_reg <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      unique case (state_reg)
        ST_ADDR, ST_RX: begin
          shift_reg <= {shift_reg[6:0], sda_s};
          cnt_reg <= cnt_reg + 4'h1;
        end
        ST_TX: cnt_reg <= cnt_reg + 4'h1;
        ST_RACK: if (sda_s) state_reg <= ST_IDLE;
        ST_IDLE, ST_ACK: ;
        default: state_reg <= ST_IDLE;
      endcase
    end else if (scl_fall) begin
      unique case (state_reg)
        ST_ADDR: begin
          if (byte_full && addr_hit) begin
            state_reg <= ST_ACK;
            rw_reg <= shift_reg[0];
            sda_oe <= 1'b1;
          end else if (byte_full) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_ACK: begin
          cnt_reg <= 4'h0;
          if (rw_reg) begin
            state_reg <= ST_TX;
            shift_reg <= rd_data;
            sda_oe <= ~rd_data[7];
          end else begin
            state_reg <= ST_RX;
            sda_oe <= 1'b0;
          end
        end
        ST_RX: begin
          if (byte_full) begin
            state_reg <= ST_ACK;
            sda_oe <= 1'b1;
          end
        end
        ST_TX: begin
          if (byte_full) begin
            state_reg <= ST_RACK;
            sda_oe <= 1'b0;
          end else begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            sda_oe <= ~shift_reg[6];
          end
        end
        ST_RACK: begin
          state_reg <= ST_TX;
          cnt_reg <= 4'h0;
          shift_reg <= rd_data;
          sda_oe <= ~rd_data[7];
        end
        ST_IDLE: ;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // the line is only ever pulled low; a one is a released line
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) sda_o <= 1'b0;
    else sda_o <= 1'b0;
  end

  // first written byte sets the pointer, later bytes auto-increment
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sub_reg <= 8'h00;
      have_sub_reg <= 1'b0;
    end else if (addr_done && addr_hit && !shift_reg[0]) begin
      have_sub_reg <= 1'b0;
    end else if (rx_done) begin
      have_sub_reg <= 1'b1;
      sub_reg <= have_sub_reg ? sub_reg + 8'h01 : shift_reg;
    end else if (tx_load) begin
      sub_reg <= sub_reg + 8'h01;
    end
  end

  // status and unmapped addresses fall through with no write effect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      masks_reg <= `PMIC_MASKS_RESET; // [R1]
      pf_en_reg <= CTRL_RESET[`PMIC_POS_PF_EN]; // [R14]
      acq_start_reg <= CTRL_RESET[`PMIC_POS_MEAS_START];
    end else begin
      if (wr_masks) masks_reg <= shift_reg[5:0]; // [R2] [R3] [R18]
      if (wr_ctrl) pf_en_reg <= shift_reg[`PMIC_POS_PF_EN]; // [R17]
      // the start bit holds for one cycle only, so reads see it cleared
      acq_start_reg <= wr_ctrl && shift_reg[`PMIC_POS_MEAS_START]; // [R15]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seal_reg <= 1'b0; // [R6]
      modified_reg <= 1'b0;
      irq_n_reg <= 1'b1;
      coin_cell_measure_req <= 1'b0;
      coin_cell_measure_done <= 1'b0;
      shutdown_req <= 1'b0;
    end else begin
      seal_reg <= freshness_seal; // [R7]
      modified_reg <= defaults_modified; // [R8]
      irq_n_reg <= ~|unmasked; // [R4] [R5]
      coin_cell_measure_req <= acq_start_reg; // [R15]
      // a settle edge beats the clear of a new start in the same cycle
      if (settle_rise) coin_cell_measure_done <= 1'b1; // [R16]
      else if (acq_start_reg) coin_cell_measure_done <= 1'b0;
      shutdown_req <= pf_en_reg & ~pf_n_s; // [R17]
    end
  end
  assign irq_out_n = irq_n_reg;

  sequence seq_start;
    acq_start_reg;
  endsequence
  sequence seq_request;
    ##1 (coin_cell_measure_req && !acq_start_reg) ##1 !coin_cell_measure_req;
  endsequence

  AST_MASK_WRITE: assert property (@(posedge clk) disable iff (!rstn) // [R2]
    $changed(masks_reg) |-> $past(wr_masks))
    else $error("mask register changed without a write");
  AST_IRQ_LOW: assert property (@(posedge clk) disable iff (!rstn) // [R4]
    (|unmasked) |=> !irq_out_n)
    else $error("unmasked event did not pull interrupt low");
  AST_IRQ_GATED: assert property (@(posedge clk) disable iff (!rstn) // [R5]
    (events != 6'h00 && unmasked == 6'h00) |=> irq_out_n)
    else $error("masked event reached the interrupt output");
  AST_SEAL: assert property (@(posedge clk) disable iff (!rstn) // [R7]
    freshness_seal |=> status_word[`PMIC_POS_SEAL])
    else $error("seal status does not follow the seal");
  AST_ADAPTER: assert property (@(posedge clk) disable iff (!rstn) // [R9]
    !adapter_detect_in [*3] |-> status_word[`PMIC_POS_ADAPTER])
    else $error("adapter status not set while pin low");
  AST_BUTTON: assert property (@(posedge clk) disable iff (!rstn) // [R10]
    pushbutton_in [*3] |-> !status_word[`PMIC_POS_BUTTON])
    else $error("button status set while pin high");
  AST_START_PULSE: assert property (@(posedge clk) disable iff (!rstn) // [R15]
    seq_start |-> seq_request)
    else $error("start bit did not self-clear into one request");
  AST_DONE_CAUSE: assert property (@(posedge clk) disable iff (!rstn) // [R16]
    $rose(coin_cell_measure_done) |-> $past(settle_rise))
    else $error("done flag set without comparators settling");
  AST_SHUTDOWN: assert property (@(posedge clk) disable iff (!rstn) // [R17]
    (pf_en_reg && !pf_n_s) |=> shutdown_req)
    else $error("power fail did not request shutdown");
  AST_CTRL_ZERO: assert property (@(posedge clk) disable iff (!rstn) // [R18]
    wr_ctrl |=> ctrl_word[7:2] == 6'h00)
    else $error("reserved control bits read nonzero");
endmodule

//--- pmic_mask_status_control_regs_test.sv
// self-checking bench for the mask, status and control register bank
`timescale 1ns/1ps
`include "pmic_regs_defines.svh"
module pmic_mask_status_control_regs_test;
  logic clk, rstn, scl, sda_drv, sda_o, sda_oe, rd_stb;
  logic [7:0] rd_byte, m;
  logic [15:0] r;
  logic done_exp;
  logic [2:0] switch_fault_flag, switch_limit_flag;
  logic freshness_seal, defaults_modified, adapter_detect_in;
  logic pushbutton_in, coin_cell_settled, power_fail_n, shutdown_req;
  logic [1:0] power_state, coin_cell_level;
  logic irq_out_n, coin_cell_measure_req, coin_cell_measure_done;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int tests_run = 0;
  int req_count = 0;
  // open-drain line: the pull-up wins unless someone pulls low
  wire sda_line = (sda_oe ? sda_o : 1'b1) & sda_drv;
  pmic_mask_status_control_regs i_pmic_mask_status_control_regs (
    .clk, .rstn, .scl_in(scl), .sda_in(sda_line), .sda_o, .sda_oe,
    .switch_fault_flag, .switch_limit_flag, .freshness_seal,
    .defaults_modified, .adapter_detect_in, .pushbutton_in, .power_state,
    .coin_cell_level, .coin_cell_settled, .power_fail_n, .irq_out_n,
    .coin_cell_measure_req, .coin_cell_measure_done, .shutdown_req
  );
  host_bus_model #(.DEV(`PMIC_DEV_ADDR)) i_host_bus_model (
    .clk, .sda_line, .scl, .sda_drv, .rd_byte, .rd_stb
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] s, input logic [7:0] v);
    i_host_bus_model.write_regs(s, v);
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  always @(posedge clk) if (rd_stb === 1'b1)
    check(rd_byte, exp_q.size() ? exp_q.pop_front() : 8'hxx);
  always @(posedge clk) if (coin_cell_measure_req === 1'b1)
    req_count <= req_count + 1;
  initial begin
    #1_000_000;
    mismatches++;
    complete_run();
  end
  initial begin
    rstn = 1'b0;
    {switch_fault_flag, switch_limit_flag} = 6'h00;
    freshness_seal = 1'b0;
    defaults_modified = 1'b0;
    adapter_detect_in = 1'b1;
    pushbutton_in = 1'b1;
    power_state = 2'h1;
    coin_cell_level = 2'h0;
    coin_cell_settled = 1'b0;
    power_fail_n = 1'b1;
    void'($urandom(32'hc9b9bab0));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    // the fourth byte runs past the bank into an unmapped offset
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h04);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    i_host_bus_model.read_regs(8'h04, 4);
    m = 8'($urandom) | 8'hc0;
    wr(8'h04, m);
    wr(8'h05, 8'hff);
    wr(8'h06, 8'hfe);
    exp_q.push_back(m & 8'h3f);
    exp_q.push_back(8'h04);
    exp_q.push_back(8'h02);
    i_host_bus_model.read_regs(8'h04, 3);
    power_fail_n <= 1'b0;
    settle();
    check(8'(shutdown_req), 8'h01);
    wr(8'h06, 8'h00);
    settle();
    check(8'(shutdown_req), 8'h00);
    power_fail_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      {switch_fault_flag, switch_limit_flag} <= 6'(1 << i);
      wr(8'h04, 8'h00);
      settle();
      check(8'(irq_out_n), 8'h00);
      wr(8'h04, 8'(1 << i));
      settle();
      check(8'(irq_out_n), 8'h01);
      wr(8'h04, 8'h3f ^ 8'(1 << i));
      settle();
      check(8'(irq_out_n), 8'h00);
    end
    {switch_fault_flag, switch_limit_flag} <= 6'h00;
    wr(8'h06, 8'h01);
    settle();
    check(8'(req_count), 8'h01);
    check(8'(coin_cell_measure_done), 8'h00);
    coin_cell_settled <= 1'b1;
    settle();
    check(8'(coin_cell_measure_done), 8'h01);
    coin_cell_settled <= 1'b0;
    exp_q.push_back(8'h00);
    i_host_bus_model.read_regs(8'h06, 1);
    wr(8'h06, 8'h01);
    settle();
    check(8'(req_count), 8'h02);
    check(8'(coin_cell_measure_done), 8'h00);
    // reset in mid-run with the bus idle brings the bank back to defaults
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h04);
    exp_q.push_back(8'h00);
    i_host_bus_model.read_regs(8'h04, 3);
    wr(8'h04, 8'h15);
    done_exp = 1'b0;
    // level is trusted only after the acquisition above
    for (int p = 0; p < 4; p++) begin
      r = 16'($urandom);
      {switch_fault_flag, switch_limit_flag} <= r[13:8];
      power_fail_n <= r[6];
      coin_cell_settled <= r[7];
      done_exp = done_exp | r[7];
      freshness_seal <= r[0];
      defaults_modified <= r[1];
      adapter_detect_in <= r[2];
      pushbutton_in <= r[3];
      power_state <= 2'(p);
      coin_cell_level <= r[5:4];
      m = {r[0], r[1], ~r[2], ~r[3], 2'(p), r[5:4]};
      exp_q.push_back(m);
      i_host_bus_model.read_regs(8'h05, 1);
      check(8'(irq_out_n), 8'(~|(r[13:8] & 6'h2a)));
      check(8'(coin_cell_measure_done), 8'(done_exp));
      check(8'(shutdown_req), 8'h00);
    end
    check(8'(exp_q.size()), 8'h00);
    complete_run();
  end
endmodule

//--- pmic_regs_defines.svh
// register offsets, field positions, reset values and bus address
`ifndef PMIC_REGS_DEFINES_SVH
`define PMIC_REGS_DEFINES_SVH
`define PMIC_DEV_ADDR 7'h2a
`define PMIC_OFF_MASKS 8'h04
`define PMIC_OFF_STATUS 8'h05
`define PMIC_OFF_CTRL 8'h06
`define PMIC_MASKS_RESET 6'h00
`define PMIC_CTRL_RESET 8'h00
`define PMIC_POS_SEAL 7
`define PMIC_POS_MODIFIED 6
`define PMIC_POS_ADAPTER 5
`define PMIC_POS_BUTTON 4
`define PMIC_POS_MEAS_START 0
`define PMIC_POS_PF_EN 1
`define PMIC_BITS_PER_BYTE 4'h8
`endif

//--- pmic_regs_pkg.sv
// types shared by the register bank
package pmic_regs_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_ACK = 6'b000100,
    ST_RX = 6'b001000,
    ST_TX = 6'b010000,
    ST_RACK = 6'b100000
  } link_state_t;
endpackage

//--- sync2.sv
// two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
